// ### design/sbcfg_top.v
// serial bus configuration register and its effects on timers and bus logic
`timescale 1ns/10ps
`default_nettype none
`include "sbcfg_defs.vh"
module sbcfg_top (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  output reg [7:0] sfr_rdata_o,
  input wire scl_i,
  input wire sda_i,
  input wire tmr0_overflow_i,
  input wire tmr1_overflow_i,
  input wire tmr2_upper_overflow_i,
  input wire tmr2_lower_overflow_i,
  input wire timeout_tmr_split_i,
  input wire xfer_start_i,
  input wire stop_seen_i,
  input wire slave_event_i,
  input wire other_event_i,
  output wire iface_enable_o,
  output wire bit_tick_o,
  output wire timeout_reload_low_o,
  output wire timeout_reload_high_o,
  output wire bus_busy_o,
  output wire bus_free_o,
  output wire event_irq_o,
  output wire [3:0] data_hold_cycles_o,
  output wire scl_s_o,
  output wire sda_s_o
);
  // ---------------------------------------------------------------
  // reset and input synchronisers
  // ---------------------------------------------------------------
  reg [1:0] rst_sync;
  wire rst_n;
  reg [1:0] scl_sync;
  reg [1:0] sda_sync;
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
    end else begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
    end
  end

  // ---------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------
  reg iface_enable;
  reg slave_event_mask;
  reg data_timing_extend;
  reg clock_low_timeout_en;
  reg bus_free_timeout_en;
  reg [1:0] bitrate_source_sel;
  reg busy;
  wire cfg_hit;
  wire free_hit;
  wire [7:0] cfg_value;

  assign cfg_hit = (sfr_addr_i == `SBCFG_CONFIG_ADDR);

  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      iface_enable <= 1'b0;
      slave_event_mask <= 1'b0;
      data_timing_extend <= 1'b0;
      clock_low_timeout_en <= 1'b0;
      bus_free_timeout_en <= 1'b0;
      bitrate_source_sel <= `SBCFG_SRC_TMR0;
    end else if (sfr_wr_i && cfg_hit) begin
      iface_enable <= sfr_wdata_i[`SBCFG_BIT_ENABLE];
      slave_event_mask <= sfr_wdata_i[`SBCFG_BIT_SLV_MASK];
      data_timing_extend <= sfr_wdata_i[`SBCFG_BIT_EXTEND];
      clock_low_timeout_en <= sfr_wdata_i[`SBCFG_BIT_TOE];
      bus_free_timeout_en <= sfr_wdata_i[`SBCFG_BIT_FTE];
      bitrate_source_sel <= sfr_wdata_i[`SBCFG_SRC_MSB:`SBCFG_SRC_LSB];
    end
  end

  assign cfg_value = {iface_enable, slave_event_mask, busy, data_timing_extend,
                      clock_low_timeout_en, bus_free_timeout_en, bitrate_source_sel};

  // read data registered; unmapped addresses read zero
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata_o <= `SBCFG_CONFIG_RESET;
    end else if (sfr_rd_i) begin
      sfr_rdata_o <= cfg_hit ? cfg_value : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // bit-rate source selection
  // ---------------------------------------------------------------
  function sel_tick;
    input [1:0] sel;
    input t0, t1, t2u, t2l;
    begin
      case (sel)
        `SBCFG_SRC_TMR0: sel_tick = t0;
        `SBCFG_SRC_TMR1: sel_tick = t1;
        `SBCFG_SRC_TMR2_UPPER: sel_tick = t2u;
        default: sel_tick = t2l;
      endcase
    end
  endfunction

  assign bit_tick_o = iface_enable & sel_tick(bitrate_source_sel, tmr0_overflow_i,
                      tmr1_overflow_i, tmr2_upper_overflow_i, tmr2_lower_overflow_i);

  // ---------------------------------------------------------------
  // bus monitoring, busy and free detection
  // ---------------------------------------------------------------
  wire lines_high;
  assign lines_high = scl_sync[1] & sda_sync[1];
  assign iface_enable_o = iface_enable;
  assign scl_s_o = scl_sync[1] & iface_enable;
  assign sda_s_o = sda_sync[1] & iface_enable;

  sbcfg_free_detect #(
    .CNT_W(4)
  ) u_free (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .run_i(iface_enable & bus_free_timeout_en & busy),
    .lines_high_i(lines_high),
    .tick_i(bit_tick_o),
    .free_o(free_hit)
  );

  // start wins over a same-cycle stop so a new transfer is never lost
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else if (!iface_enable) begin
      busy <= 1'b0;
    end else if (xfer_start_i) begin
      busy <= 1'b1;
    end else if (stop_seen_i || free_hit) begin
      busy <= 1'b0;
    end
  end
  assign bus_busy_o = busy;
  assign bus_free_o = free_hit;

  // ---------------------------------------------------------------
  // timing, timeout timer control and events
  // ---------------------------------------------------------------
  assign data_hold_cycles_o = data_timing_extend ? `SBCFG_EXTEND_CYCLES
                                                 : `SBCFG_NORMAL_CYCLES;

  // timer counts only while clock held low, except its low byte in split mode, which is never reloaded; its period is left to software
  wire reload_req;
  assign reload_req = iface_enable & clock_low_timeout_en & scl_sync[1];
  assign timeout_reload_high_o = reload_req;
  assign timeout_reload_low_o = reload_req & ~timeout_tmr_split_i;

  assign event_irq_o = iface_enable & (other_event_i |
                       (slave_event_i & ~slave_event_mask));
endmodule
`default_nettype wire

// ### design/sbcfg_defs.vh
// constants for the serial bus configuration block
`ifndef SBCFG_DEFS_VH
`define SBCFG_DEFS_VH

`define SBCFG_CONFIG_ADDR 8'hc1
`define SBCFG_CONFIG_RESET 8'h00
`define SBCFG_BIT_ENABLE 7
`define SBCFG_BIT_SLV_MASK 6
`define SBCFG_BIT_BUSY 5
`define SBCFG_BIT_EXTEND 4
`define SBCFG_BIT_TOE 3
`define SBCFG_BIT_FTE 2
`define SBCFG_SRC_MSB 1
`define SBCFG_SRC_LSB 0
`define SBCFG_SRC_TMR0 2'h0
`define SBCFG_SRC_TMR1 2'h1
`define SBCFG_SRC_TMR2_UPPER 2'h2
`define SBCFG_SRC_TMR2_LOWER 2'h3
`define SBCFG_FREE_PERIODS 4'ha
`define SBCFG_EXTEND_CYCLES 4'hc
`define SBCFG_NORMAL_CYCLES 4'h3

`endif

// ### design/sbcfg_free_detect.v
// bus-free detector counting selected overflow pulses while both lines are high
`timescale 1ns/10ps
`default_nettype none
`include "sbcfg_defs.vh"
module sbcfg_free_detect #(
  parameter CNT_W = 4
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire run_i,
  input wire lines_high_i,
  input wire tick_i,
  output reg free_o
);
  reg [CNT_W-1:0] count;

  // free once more than ten ticks pass with both lines high
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= {CNT_W{1'b0}};
      free_o <= 1'b0;
    end else if (!run_i || !lines_high_i) begin
      count <= {CNT_W{1'b0}};
      free_o <= 1'b0;
    end else if (tick_i && !free_o) begin
      if (count == `SBCFG_FREE_PERIODS) begin
        free_o <= 1'b1;
      end else begin
        count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/sbcfg_properties.sv
// port assertions for the serial bus configuration block
`timescale 1ns/10ps
`default_nettype none
module sbcfg_properties (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic timeout_tmr_split_i,
  input wire logic xfer_start_i,
  input wire logic stop_seen_i,
  input wire logic other_event_i,
  input wire logic iface_enable_o,
  input wire logic bit_tick_o,
  input wire logic timeout_reload_low_o,
  input wire logic timeout_reload_high_o,
  input wire logic bus_busy_o,
  input wire logic bus_free_o,
  input wire logic event_irq_o,
  input wire logic scl_s_o,
  input wire logic sda_s_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  property p_off; !iface_enable_o |-> !(bit_tick_o || event_irq_o || scl_s_o); endproperty
  a_off: assert property (p_off) else $error("active while off");
  property p_irq; iface_enable_o && other_event_i |-> event_irq_o; endproperty
  a_irq: assert property (p_irq) else $error("event lost");
  property p_set; $rose(bus_busy_o) |-> $past(xfer_start_i); endproperty
  a_set: assert property (p_set) else $error("busy without start");
  property p_stop; stop_seen_i && !xfer_start_i |=> !bus_busy_o; endproperty
  a_stop: assert property (p_stop) else $error("busy after stop");
  property p_drop; $fell(bus_busy_o) && iface_enable_o
    |-> $past(stop_seen_i) || $past(bus_free_o); endproperty
  a_drop: assert property (p_drop) else $error("busy dropped early");
  property p_free; $rose(bus_free_o) |-> ($past(scl_s_o) && $past(sda_s_o)) ##1 !bus_busy_o;
  endproperty
  a_free: assert property (p_free) else $error("bad free");
  property p_rlh; timeout_reload_high_o |-> scl_s_o; endproperty
  a_rlh: assert property (p_rlh) else $error("reload with clock low");
  property p_rll; timeout_reload_low_o |-> timeout_reload_high_o && !timeout_tmr_split_i;
  endproperty
  a_rll: assert property (p_rll) else $error("low byte held in split");
endmodule
bind sbcfg_top sbcfg_properties i_props (.*);
`default_nettype wire

// ### verification/sbcfg_bus_model.sv
// far-side master: start, clock at link rate, stop; lines pulled up when released
`timescale 1ns/10ps
`default_nettype none
module sbcfg_bus_model (
  input wire logic run_i,
  output logic scl_o = 1,
  output logic sda_o = 1
);
  always begin
    wait (run_i);
    sda_o = 0;
    while (run_i) #62.5 scl_o = ~scl_o;
    #62.5 scl_o = 1;
    #62.5 sda_o = 1;
  end
endmodule
`default_nettype wire

// ### verification/sbcfg_bench.sv
// self-checking bench for the serial bus configuration block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %h got %h", n, e, a); end end
module sbcfg_bench;
  logic sys_clk_i = 0, resetn_i = 0, sfr_wr_i = 0, sfr_rd_i = 0, timeout_tmr_split_i = 0;
  logic xfer_start_i = 0, stop_seen_i = 0, slave_event_i = 0, other_event_i = 0, run = 0;
  logic [7:0] sfr_addr_i = 0, sfr_wdata_i = 0;
  logic [3:0] ov = 0;
  wire logic scl_i, sda_i, iface_enable_o, bit_tick_o, timeout_reload_low_o, scl_s_o;
  wire logic timeout_reload_high_o, bus_busy_o, bus_free_o, event_irq_o, sda_s_o;
  wire logic [7:0] sfr_rdata_o;
  wire logic [3:0] data_hold_cycles_o;
  wire logic tmr0_overflow_i = ov[0], tmr1_overflow_i = ov[1];
  wire logic tmr2_upper_overflow_i = ov[2], tmr2_lower_overflow_i = ov[3];
  int num_errors = 0, checked = 0;
  sbcfg_top i_dut (.*);
  sbcfg_bus_model i_bus (.run_i(run), .scl_o(scl_i), .sda_o(sda_i));
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  task cyc(input int n); repeat (n) @(posedge sys_clk_i); #1; endtask
  task wr(input logic [7:0] d);
    sfr_addr_i = 8'hc1; sfr_wdata_i = d; sfr_wr_i = 1; cyc(1); sfr_wr_i = 0;
  endtask
  task rd(input logic [7:0] a, e);
    sfr_addr_i = a; sfr_rd_i = 1; cyc(1); sfr_rd_i = 0; `CHK("rdata", e, sfr_rdata_o)
  endtask
  task test_done;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    test_done;
  end
  initial begin
    cyc(5);
    resetn_i = 1;
    cyc(3);
    rd(8'hc1, 8'h00);
    rd(8'hc0, 8'h00);
    wr(8'hff);
    rd(8'hc1, 8'hdf);
    `CHK("hold", 4'hc, data_hold_cycles_o)
    for (int s = 0; s < 4; s++) begin
      wr(8'h80 + s[7:0]);
      for (int t = 0; t < 4; t++) begin
        ov = 4'h1 << t;
        #0.5 `CHK("tick", t == s, bit_tick_o)
      end
      ov = 0;
    end
    `CHK("hold", 4'h3, data_hold_cycles_o)
    wr(8'hc0);
    slave_event_i = 1;
    #1 `CHK("irq", 1'b0, event_irq_o)
    wr(8'h80);
    `CHK("irq", 1'b1, event_irq_o)
    other_event_i = 1;
    wr(8'h88);
    `CHK("reload", 2'h3, {timeout_reload_high_o, timeout_reload_low_o})
    timeout_tmr_split_i = 1;
    #1 `CHK("reload", 2'h2, {timeout_reload_high_o, timeout_reload_low_o})
    // the timeout timer period is software's choice, so only the reload is seen here
    run = 1;
    wait (!scl_i);
    cyc(4);
    `CHK("reload", 2'h0, {timeout_reload_high_o, timeout_reload_low_o})
    `CHK("lines", 2'h0, {scl_s_o, sda_s_o})
    run = 0;
    cyc(60);
    wr(8'h84);
    xfer_start_i = 1;
    cyc(1);
    xfer_start_i = 0;
    `CHK("busy", 1'b1, bus_busy_o)
    stop_seen_i = 1;
    cyc(1);
    stop_seen_i = 0;
    `CHK("busy", 1'b0, bus_busy_o)
    xfer_start_i = 1;
    cyc(1);
    xfer_start_i = 0;
    ov = 1;
    cyc(10);
    `CHK("free", 1'b0, bus_free_o)
    cyc(1);
    ov = 0;
    `CHK("free", 1'b1, bus_free_o)
    cyc(1);
    `CHK("busy", 1'b0, bus_busy_o)
    wr(8'h00);
    ov = 1;
    #1 `CHK("off", 4'h0, {iface_enable_o, bit_tick_o, scl_s_o, sda_s_o})
    test_done;
  end
endmodule
`default_nettype wire
